// >>> dsp_dram_model.sv
`timescale 1ns/1ps
module dsp_dram_model (
    input wire logic [1:0] ras_n,
    input wire logic [1:0] col_hi_n,
    input wire logic [1:0] col_lo_n,
    input wire logic we_n,
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] flip,
    output logic [15:0] rdata,
    output logic [1:0] rpar
);
    bit [15:0] mem [16];
    logic [15:0] last = 16'h0;
    wire [3:0] key = {~ras_n[1], addr[2:0]};
    wire rd = we_n && (col_hi_n & col_lo_n) != 2'h3;
    always @(negedge col_hi_n[0] or negedge col_hi_n[1]) begin
        if (!we_n) mem[key][15:8] = wdata[15:8];
    end
    always @(negedge col_lo_n[0] or negedge col_lo_n[1]) begin
        if (!we_n) mem[key][7:0] = wdata[7:0];
    end
    always @(rd or key) begin
        if (rd) last = mem[key];
    end
    // released lines show the inverse of the last value
    assign rdata = rd ? mem[key] : ~last;
    assign rpar = {~^rdata[15:8], ~^rdata[7:0]} ^ flip ^ {2{~rd}};
endmodule

// >>> dsp_parity.sv
`timescale 1ns/1ps
module dsp_parity (
    // byte data
    input wire logic [15:0] data,
    // odd parity bits, one per byte
    output logic [1:0] odd_bits
);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_byte
            assign odd_bits[g] = ~^data[g*8 +: 8];
        end
    endgenerate
endmodule

// >>> dsp_pkg.sv
package dsp_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int BANKS = 2;
    // reset levels of the strobes (inactive high)
    localparam logic [1:0] STROBE_IDLE = 2'h3;
    localparam logic WRITE_IDLE = 1'h1;
    // row phase length in core cycles; the column phase lasts COL_CYCLES + 2
    localparam int ROW_CYCLES = 2;
    localparam int COL_CYCLES = 2;
    localparam logic [1:0] PHASE_ONE = 2'h1;

    typedef enum logic [1:0] {
        DSP_IDLE = 2'b00,
        DSP_ROW = 2'b01,
        DSP_COL = 2'b11,
        DSP_DONE = 2'b10
    } dsp_state_t;

    typedef struct packed {
        logic bank;
        logic write;
        logic hi_byte;
        logic lo_byte;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } dsp_req_t;
endpackage

// >>> dsp_port.sv
`timescale 1ns/1ps
module dsp_port (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // configuration
    input wire logic SINGLE_BANK,
    input wire logic PARITY_EN,
    // request
    input wire logic REQ_VALID,
    input wire dsp_pkg::dsp_req_t REQ,
    output logic REQ_READY,
    // answer
    output logic DONE,
    output logic [15:0] RDATA,
    output logic PARITY_ERR,
    output logic PARITY_ERR_PULSE,
    input wire logic PARITY_ERR_CLR,
    // dram pins
    output logic [11:0] SYSTEM_ADDRESS_BUS,
    output logic [1:0] ROW_STROBE_N,
    output logic [1:0] COL_STROBE_HIGH_BYTE_N,
    output logic [1:0] COL_STROBE_LOW_BYTE_N,
    output logic WRITE_STROBE_N,
    input wire logic [15:0] DATA_IN,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic [1:0] DRAM_PARITY_LINE_IN,
    output logic [1:0] DRAM_PARITY_LINE_OUT,
    output logic [1:0] DRAM_PARITY_LINE_OE
);
    dsp_pkg::dsp_state_t state;
    dsp_pkg::dsp_req_t cur;
    logic [1:0] cnt;
    logic bank_sel;
    logic [15:0] din_s1, din_s2;
    logic [1:0] par_s1, par_s2;
    logic [1:0] wpar, rpar;
    logic bad;
    logic fin;

    // active-low strobe pair with only the selected lane pulled low, and only when on is set
    function automatic logic [1:0] lane_n(input logic sel, input logic on);
        logic [1:0] v;
        v = dsp_pkg::STROBE_IDLE;
        v[sel] = ~on;
        return v;
    endfunction

    // single-bank mode folds every access onto bank zero
    assign bank_sel = SINGLE_BANK ? 1'b0 : cur.bank;
    // a new request is taken only while idle
    assign REQ_READY = (state == dsp_pkg::DSP_IDLE);

    // pin inputs pass two flip-flops
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            din_s1 <= 16'h0000;
            din_s2 <= 16'h0000;
            par_s1 <= 2'h0;
            par_s2 <= 2'h0;
        end else begin
            din_s1 <= DATA_IN;
            din_s2 <= din_s1;
            par_s1 <= DRAM_PARITY_LINE_IN;
            par_s2 <= par_s1;
        end
    end

    dsp_parity u_wpar (
        .data(cur.wdata),
        .odd_bits(wpar)
    );
    dsp_parity u_rpar (
        .data(din_s2),
        .odd_bits(rpar)
    );

    // check only the bytes that were strobed
    assign bad = PARITY_EN && !cur.write && (
        (cur.lo_byte && (rpar[0] != par_s2[0])) ||
        (cur.hi_byte && (rpar[1] != par_s2[1])));

    // sequencer
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state <= dsp_pkg::DSP_IDLE;
            cnt <= 2'h0;
            cur <= '0;
        end else begin
            case (state)
                dsp_pkg::DSP_IDLE: begin
                    if (REQ_VALID) begin
                        cur <= REQ;
                        cnt <= 2'(dsp_pkg::ROW_CYCLES - 1);
                        state <= dsp_pkg::DSP_ROW;
                    end
                end
                dsp_pkg::DSP_ROW: begin
                    if (cnt == 2'h0) begin
                        cnt <= 2'(dsp_pkg::COL_CYCLES + 1);
                        state <= dsp_pkg::DSP_COL;
                    end else begin
                        cnt <= cnt - 2'h1;
                    end
                end
                dsp_pkg::DSP_COL: begin
                    if (cnt == 2'h0) begin
                        state <= dsp_pkg::DSP_DONE;
                    end else begin
                        cnt <= cnt - 2'h1;
                    end
                end
                default: begin
                    state <= dsp_pkg::DSP_IDLE;
                end
            endcase
        end
    end

    // pin drivers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SYSTEM_ADDRESS_BUS <= 12'h000;
            ROW_STROBE_N <= dsp_pkg::STROBE_IDLE;
            COL_STROBE_HIGH_BYTE_N <= dsp_pkg::STROBE_IDLE;
            COL_STROBE_LOW_BYTE_N <= dsp_pkg::STROBE_IDLE;
            WRITE_STROBE_N <= dsp_pkg::WRITE_IDLE;
            DATA_OUT <= 16'h0000;
            DATA_OE <= 1'b0;
            DRAM_PARITY_LINE_OUT <= 2'h0;
            DRAM_PARITY_LINE_OE <= 2'h0;
        end else begin
            ROW_STROBE_N <= dsp_pkg::STROBE_IDLE;
            COL_STROBE_HIGH_BYTE_N <= dsp_pkg::STROBE_IDLE;
            COL_STROBE_LOW_BYTE_N <= dsp_pkg::STROBE_IDLE;
            WRITE_STROBE_N <= dsp_pkg::WRITE_IDLE;
            DATA_OE <= 1'b0;
            DRAM_PARITY_LINE_OE <= 2'h0;
            case (state)
                dsp_pkg::DSP_ROW: begin
                    SYSTEM_ADDRESS_BUS <= cur.row;
                    // row address set up one cycle ahead of the falling strobe
                    if (cnt != 2'(dsp_pkg::ROW_CYCLES - 1)) begin
                        ROW_STROBE_N <= lane_n(bank_sel, 1'b1);
                    end
                end
                dsp_pkg::DSP_COL: begin
                    SYSTEM_ADDRESS_BUS <= cur.col;
                    ROW_STROBE_N <= lane_n(bank_sel, 1'b1);
                    WRITE_STROBE_N <= ~cur.write;
                    DATA_OUT <= cur.wdata;
                    DATA_OE <= cur.write;
                    DRAM_PARITY_LINE_OUT <= wpar;
                    DRAM_PARITY_LINE_OE <= {2{cur.write & PARITY_EN}};
                    if (cnt <= dsp_pkg::PHASE_ONE) begin
                        COL_STROBE_HIGH_BYTE_N <= lane_n(bank_sel, cur.hi_byte);
                        COL_STROBE_LOW_BYTE_N <= lane_n(bank_sel, cur.lo_byte);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // completion runs one cycle behind the done state, so that the data and
    // parity sampled while the column strobes were low have passed both
    // synchroniser stages before they are captured and checked
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            fin <= 1'b0;
        end else begin
            fin <= (state == dsp_pkg::DSP_DONE);
        end
    end

    // read capture and completion pulses
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0000;
            DONE <= 1'b0;
            PARITY_ERR_PULSE <= 1'b0;
        end else begin
            DONE <= fin;
            PARITY_ERR_PULSE <= 1'b0;
            if (fin) begin
                if (!cur.write) begin
                    RDATA <= din_s2;
                end
                if (bad) begin
                    PARITY_ERR_PULSE <= 1'b1;
                end
            end
        end
    end

    // sticky error flag; a new error beats a clear in the same cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PARITY_ERR <= 1'b0;
        end else begin
            if (fin && bad) begin
                PARITY_ERR <= 1'b1;
            end else if (PARITY_ERR_CLR) begin
                PARITY_ERR <= 1'b0;
            end
        end
    end
endmodule

// >>> dsp_port_sva.sv
`timescale 1ns/1ps
module dsp_port_sva (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // configuration, request and answer
    input wire logic SINGLE_BANK,
    input wire logic PARITY_EN,
    input wire logic REQ_VALID,
    input wire dsp_pkg::dsp_req_t REQ,
    input wire logic REQ_READY,
    input wire logic DONE,
    input wire logic PARITY_ERR,
    input wire logic PARITY_ERR_PULSE,
    input wire logic PARITY_ERR_CLR,
    // dram pins
    input wire logic [11:0] SYSTEM_ADDRESS_BUS,
    input wire logic [1:0] ROW_STROBE_N,
    input wire logic [1:0] COL_STROBE_HIGH_BYTE_N,
    input wire logic [1:0] COL_STROBE_LOW_BYTE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [15:0] DATA_OUT,
    input wire logic [1:0] DRAM_PARITY_LINE_OUT,
    input wire logic [1:0] DRAM_PARITY_LINE_OE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    wire take = REQ_VALID && REQ_READY;
    AST_DONE_LAT: assert property (take |-> ##9 DONE)
        else $error("done late");
    AST_ROW_ADDR: assert property (take |-> ##2 SYSTEM_ADDRESS_BUS == $past(REQ.row, 2))
        else $error("row address wrong");
    AST_ROW_STB: assert property (take |-> ##3 ROW_STROBE_N ==
        (SINGLE_BANK | ~$past(REQ.bank, 3) ? 2'h2 : 2'h1))
        else $error("row strobe wrong");
    AST_COL_HI: assert property (take |-> ##6 COL_STROBE_HIGH_BYTE_N == ~({1'h0,
        $past(REQ.hi_byte, 6)} << (~SINGLE_BANK & $past(REQ.bank, 6))))
        else $error("high column strobe wrong");
    AST_COL_LO: assert property (take |-> ##6 COL_STROBE_LOW_BYTE_N == ~({1'h0,
        $past(REQ.lo_byte, 6)} << (~SINGLE_BANK & $past(REQ.bank, 6))))
        else $error("low column strobe wrong");
    AST_WRITE_STB: assert property (take |-> ##4 WRITE_STROBE_N == ~$past(REQ.write, 4))
        else $error("write strobe wrong");
    AST_PAR_OFF: assert property (!PARITY_EN && !$past(PARITY_EN, 8)
        |-> DRAM_PARITY_LINE_OE == 2'h0)
        else $error("parity driven while off");
    AST_PAR_GEN: assert property (|DRAM_PARITY_LINE_OE
        |-> DRAM_PARITY_LINE_OUT == {~^DATA_OUT[15:8], ~^DATA_OUT[7:0]})
        else $error("parity not odd");
    AST_ERR_PULSE: assert property (PARITY_ERR_PULSE |-> DONE && PARITY_ERR)
        else $error("error pulse alone");
    AST_ERR_STICKY: assert property (PARITY_ERR && !PARITY_ERR_CLR |=> PARITY_ERR)
        else $error("error flag lost");
endmodule
bind dsp_port dsp_port_sva u_sva (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .SINGLE_BANK(SINGLE_BANK),
    .PARITY_EN(PARITY_EN),
    .REQ_VALID(REQ_VALID),
    .REQ(REQ),
    .REQ_READY(REQ_READY),
    .DONE(DONE),
    .PARITY_ERR(PARITY_ERR),
    .PARITY_ERR_PULSE(PARITY_ERR_PULSE),
    .PARITY_ERR_CLR(PARITY_ERR_CLR),
    .SYSTEM_ADDRESS_BUS(SYSTEM_ADDRESS_BUS),
    .ROW_STROBE_N(ROW_STROBE_N),
    .COL_STROBE_HIGH_BYTE_N(COL_STROBE_HIGH_BYTE_N),
    .COL_STROBE_LOW_BYTE_N(COL_STROBE_LOW_BYTE_N),
    .WRITE_STROBE_N(WRITE_STROBE_N),
    .DATA_OUT(DATA_OUT),
    .DRAM_PARITY_LINE_OUT(DRAM_PARITY_LINE_OUT),
    .DRAM_PARITY_LINE_OE(DRAM_PARITY_LINE_OE)
);

// >>> dsp_port_tb.sv
`timescale 1ns/1ps
module dsp_port_tb;
    logic CORE_CLK = 1'h0, RST = 1'h1, SINGLE_BANK = 1'h0, PARITY_EN = 1'h0;
    logic REQ_VALID = 1'h0, PARITY_ERR_CLR = 1'h0, REQ_READY, DONE, PARITY_ERR;
    logic PARITY_ERR_PULSE, WRITE_STROBE_N, DATA_OE, exp_err = 1'h0;
    dsp_pkg::dsp_req_t REQ = '0;
    logic [15:0] RDATA, DATA_IN, DATA_OUT, m_data;
    logic [11:0] SYSTEM_ADDRESS_BUS;
    logic [1:0] ROW_STROBE_N, COL_STROBE_HIGH_BYTE_N, COL_STROBE_LOW_BYTE_N, m_par;
    logic [1:0] DRAM_PARITY_LINE_IN, DRAM_PARITY_LINE_OUT, DRAM_PARITY_LINE_OE, flip = 2'h0;
    logic [31:0] rnd = 32'hD8746092;
    bit [15:0] ref_mem [16];
    int n_fail = 0, n_checks = 0;
    always #12.5 CORE_CLK = ~CORE_CLK;
    // shared wires: the enabled party drives, else the dram model
    assign DATA_IN = DATA_OE ? DATA_OUT : m_data;
    assign DRAM_PARITY_LINE_IN = (DRAM_PARITY_LINE_OE & DRAM_PARITY_LINE_OUT)
        | (~DRAM_PARITY_LINE_OE & m_par);
    dsp_port dut (.*);
    dsp_dram_model mdl (.ras_n(ROW_STROBE_N), .col_hi_n(COL_STROBE_HIGH_BYTE_N),
        .col_lo_n(COL_STROBE_LOW_BYTE_N), .we_n(WRITE_STROBE_N), .addr(SYSTEM_ADDRESS_BUS),
        .wdata(DATA_IN), .flip(flip), .rdata(m_data), .rpar(m_par));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one access from take to done; random fields come from rnd
    task automatic access(input logic w, input logic [1:0] be);
        int i;
        logic [3:0] k;
        logic [15:0] m;
        logic e;
        m = {{8{be[1]}}, {8{be[0]}}};
        k = {rnd[7] & ~SINGLE_BANK, rnd[6:4]};
        e = PARITY_EN & |flip;
        chk(REQ_READY, 1'h1);
        REQ_VALID = 1'h1;
        REQ = '{rnd[7], w, be[1], be[0], rnd[27:16], rnd[15:4], rnd[31:16]};
        @(negedge CORE_CLK);
        REQ_VALID = 1'h0;
        for (i = 1; i < 20 && DONE !== 1'h1; i++) @(negedge CORE_CLK);
        chk(i, 9);
        if (i >= 20) print_verdict();
        if (w) ref_mem[k] = (ref_mem[k] & ~m) | (rnd[31:16] & m);
        else begin
            exp_err = exp_err | e;
            chk(RDATA, ref_mem[k]);
            chk(PARITY_ERR_PULSE, e);
            chk(PARITY_ERR, exp_err);
        end
    endtask
    initial begin
        repeat (5) @(negedge CORE_CLK);
        chk({ROW_STROBE_N, COL_STROBE_HIGH_BYTE_N, COL_STROBE_LOW_BYTE_N, WRITE_STROBE_N,
            DATA_OE, DRAM_PARITY_LINE_OE, DONE, PARITY_ERR}, 12'hFE0);
        RST = 1'h0;
        for (int n = 0; n < 64; n++) begin
            repeat (16) rnd = lfsr(rnd);
            SINGLE_BANK = rnd[0];
            PARITY_EN = rnd[1];
            flip = 2'h0;
            access(1'h1, rnd[3:2]);
            flip = n[0] ? rnd[9:8] : 2'h0;
            access(1'h0, 2'h3);
            if (rnd[12]) begin
                PARITY_ERR_CLR = 1'h1;
                exp_err = 1'h0;
                @(negedge CORE_CLK);
                PARITY_ERR_CLR = 1'h0;
            end
        end
        print_verdict();
    end
endmodule
